// ### hw/hbc_top.sv
// Half-bridge output control: Avalon-MM registers, interlock, chopping and protection
//
// Behaviour
// - Hall flags track enabled inputs, reset clears
// - Reset clears bridge output register, all off
// - MOSFETs switch individually only with stage enable
// - Both bits set drives high side only
// - Turn on waits for opposite gate off
// - Output register holds high/low bits per bridge
// - Low-side bit drives low MOSFET, reset clears
// - High-side bit drives high MOSFET, reset clears
// - Limit hit turns low off until chop edge
// - Offset chop: bridges 3,4 use falling edge
// - Gain bit picks sense range, reset clears
// - Recirculation output high while any bridge recirculates
// - Overtemp warning flag; enabled trip resets outputs
// - Overcurrent kills its side, sets flag
// - Write one clears overcurrent, re-enables outputs
// - Voltage flags disable all bridge outputs
// - Write one clears voltage flag, resets if present
// - Control register layout, bits 5:3 read zero
// - Limit field codes map to five limits
// - Lamp switch needs stage enable and own bit
// - Stage enable at system control bit 7
// - Writing zero to overcurrent flag does nothing
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module hbc_top (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // Avalon-MM slave
  input  wire logic [5:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [3:0]                avs_byteenable,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Analog and pin inputs, asynchronous
  input  wire logic                      chop_clock_input,
  input  wire logic [2:0]                hall_sense_in,
  input  wire hbc_pkg::hbc_fault_t       fault_in,
  input  wire hbc_pkg::hbc_bridge_sense_t bridge_in,
  // Power stage outputs
  output logic      [3:0]                hs_drive,
  output logic      [3:0]                ls_drive,
  output logic                           lamp_drive,
  output logic      [2:0]                hall_input_enable,
  output logic                           sense_gain_select,
  output logic      [2:0]                current_limit_select,
  output logic                           recirculation_detect,
  output logic                           thermal_reset
);

  // Register storage
  logic [7:0]  half_bridge_output_q;
  logic        ofc_q;
  logic        gain_q;
  logic [2:0]  cls_q;
  logic        pse_q;
  logic        htre_q;
  logic        lamp_on_q;
  logic [2:0]  hall_en_q;
  logic [2:0]  hall_flags_q;
  logic        lvf_q;
  logic        hvf_q;
  logic        htf_q;
  logic        hs_oc_q;
  logic        ls_oc_q;
  logic        trip_q;
  logic [3:0]  chop_off_q;
  logic [3:0]  hs_drive_q;
  logic [3:0]  ls_drive_q;
  logic        lamp_q;
  logic        recirc_q;
  logic        wait_q;
  logic [31:0] rdata_q;

  // Synchronisers; first stage feeds only the second
  logic [2:0]  hall_m_q;
  logic [2:0]  hall_s_q;
  hbc_pkg::hbc_fault_t        flt_m_q;
  hbc_pkg::hbc_fault_t        flt_s_q;
  hbc_pkg::hbc_bridge_sense_t br_m_q;
  hbc_pkg::hbc_bridge_sense_t br_s_q;
  logic        chop_m_q;
  logic        chop_s_q;
  logic        chop_p_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hall_m_q <= hbc_pkg::HALL0;
      hall_s_q <= hbc_pkg::HALL0;
      flt_m_q  <= '0;
      flt_s_q  <= '0;
      br_m_q   <= '0;
      br_s_q   <= '0;
      chop_m_q <= 1'b0;
      chop_s_q <= 1'b0;
      chop_p_q <= 1'b0;
    end else begin
      hall_m_q <= hall_sense_in;
      hall_s_q <= hall_m_q;
      flt_m_q  <= fault_in;
      flt_s_q  <= flt_m_q;
      br_m_q   <= bridge_in;
      br_s_q   <= br_m_q;
      chop_m_q <= chop_clock_input;
      chop_s_q <= chop_m_q;
      chop_p_q <= chop_s_q;
    end
  end

  // Single-cycle chop edge pulses
  logic chop_rise;
  logic chop_fall;
  assign chop_rise = chop_s_q & ~chop_p_q;
  assign chop_fall = ~chop_s_q & chop_p_q;

  // Register access decode
  function automatic logic idx_ok(input logic [3:0] idx);
    idx_ok = (idx == hbc_pkg::IDX_HALF_BRIDGE_OUTPUT) || (idx == hbc_pkg::IDX_HALF_BRIDGE_CONTROL) ||
             (idx == hbc_pkg::IDX_SYSTEM_CONTROL_REGISTER) || (idx == hbc_pkg::IDX_PROTCTL) ||
             (idx == hbc_pkg::IDX_IFR) || (idx == hbc_pkg::IDX_HACTL) ||
             (idx == hbc_pkg::IDX_HASTAT) || (idx == hbc_pkg::IDX_POWER_OUTPUT_REGISTER) ||
             (idx == hbc_pkg::IDX_SYSTEM_STATUS_REGISTER);
  endfunction

  // Picks the high or low bits of the output register
  function automatic logic [3:0] side_bits(input logic [7:0] r, input logic hi);
    side_bits = hi ? {r[7], r[5], r[3], r[1]} : {r[6], r[4], r[2], r[0]};
  endfunction

  logic [3:0] idx;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  assign idx = avs_address[5:2];
  assign acc = (avs_address[1:0] == 2'h0) && idx_ok(idx);
  assign wr  = avs_write && !wait_q && acc && avs_byteenable[0];
  assign wd  = avs_writedata[7:0];

  logic wr_half_bridge_output;
  logic wr_half_bridge_control;
  logic wr_system_control_register;
  logic wr_prot;
  logic wr_ifr;
  logic wr_hactl;
  logic wr_power_output_register;
  logic wr_stat;
  assign wr_half_bridge_output  = wr && (idx == hbc_pkg::IDX_HALF_BRIDGE_OUTPUT);
  assign wr_half_bridge_control  = wr && (idx == hbc_pkg::IDX_HALF_BRIDGE_CONTROL);
  assign wr_system_control_register = wr && (idx == hbc_pkg::IDX_SYSTEM_CONTROL_REGISTER);
  assign wr_prot   = wr && (idx == hbc_pkg::IDX_PROTCTL);
  assign wr_ifr    = wr && (idx == hbc_pkg::IDX_IFR);
  assign wr_hactl  = wr && (idx == hbc_pkg::IDX_HACTL);
  assign wr_power_output_register   = wr && (idx == hbc_pkg::IDX_POWER_OUTPUT_REGISTER);
  assign wr_stat   = wr && (idx == hbc_pkg::IDX_SYSTEM_STATUS_REGISTER);

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  // Read data captured one edge ahead of the accepting edge
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (!acc) begin
      rd_byte = 8'h00;
    end else if (idx == hbc_pkg::IDX_HALF_BRIDGE_OUTPUT) begin
      rd_byte = half_bridge_output_q;
    end else if (idx == hbc_pkg::IDX_HALF_BRIDGE_CONTROL) begin
      rd_byte = {ofc_q, gain_q, 3'h0, cls_q};
    end else if (idx == hbc_pkg::IDX_SYSTEM_CONTROL_REGISTER) begin
      rd_byte[hbc_pkg::SYSTEM_CONTROL_REGISTER_PSE] = pse_q;
    end else if (idx == hbc_pkg::IDX_PROTCTL) begin
      rd_byte[hbc_pkg::PROTCTL_HTRE] = htre_q;
    end else if (idx == hbc_pkg::IDX_IFR) begin
      rd_byte[hbc_pkg::IFR_LVF] = lvf_q;
      rd_byte[hbc_pkg::IFR_HVF] = hvf_q;
      rd_byte[hbc_pkg::IFR_HTF] = htf_q;
    end else if (idx == hbc_pkg::IDX_HACTL) begin
      rd_byte[2:0] = hall_en_q;
    end else if (idx == hbc_pkg::IDX_HASTAT) begin
      rd_byte[2:0] = hall_flags_q;
    end else if (idx == hbc_pkg::IDX_POWER_OUTPUT_REGISTER) begin
      rd_byte[hbc_pkg::POWER_OUTPUT_REGISTER_LAMP] = lamp_on_q;
    end else begin
      rd_byte[hbc_pkg::STAT_HBOCF] = hs_oc_q | ls_oc_q;
      rd_byte[hbc_pkg::STAT_LVF]   = lvf_q;
      rd_byte[hbc_pkg::STAT_HVF]   = hvf_q;
      rd_byte[hbc_pkg::STAT_HTF]   = htf_q;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_q <= hbc_pkg::WORD0;
    end else if (avs_read && wait_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Software control registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      half_bridge_output_q   <= hbc_pkg::HALF_BRIDGE_OUTPUT_RST;
      ofc_q     <= 1'b0;
      gain_q    <= 1'b0;
      cls_q     <= hbc_pkg::CLS_RST;
      pse_q     <= 1'b0;
      htre_q    <= 1'b0;
      lamp_on_q <= 1'b0;
      hall_en_q <= hbc_pkg::HALL0;
    end else begin
      if (wr_half_bridge_output) begin
        half_bridge_output_q <= wd;
      end
      if (wr_half_bridge_control) begin
        ofc_q  <= wd[hbc_pkg::HALF_BRIDGE_CONTROL_OFC];
        gain_q <= wd[hbc_pkg::HALF_BRIDGE_CONTROL_GAIN];
        cls_q  <= wd[2:0];
      end
      if (wr_system_control_register) begin
        pse_q <= wd[hbc_pkg::SYSTEM_CONTROL_REGISTER_PSE];
      end
      if (wr_prot) begin
        htre_q <= wd[hbc_pkg::PROTCTL_HTRE];
      end
      if (wr_power_output_register) begin
        lamp_on_q <= wd[hbc_pkg::POWER_OUTPUT_REGISTER_LAMP];
      end
      if (wr_hactl) begin
        hall_en_q <= wd[2:0];
      end
    end
  end

  // Hall flags follow the sensor only while enabled
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hall_flags_q <= hbc_pkg::HALL0;
    end else begin
      hall_flags_q <= hall_s_q & hall_en_q;
    end
  end

  // Protection flags; a pending event beats a write-one clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvf_q   <= 1'b0;
      hvf_q   <= 1'b0;
      htf_q   <= 1'b0;
      hs_oc_q <= 1'b0;
      ls_oc_q <= 1'b0;
      trip_q  <= 1'b0;
    end else begin
      lvf_q <= flt_s_q.low_voltage | (lvf_q & ~(wr_ifr & wd[hbc_pkg::IFR_LVF]));
      hvf_q <= flt_s_q.high_voltage | (hvf_q & ~(wr_ifr & wd[hbc_pkg::IFR_HVF]));
      htf_q <= flt_s_q.overtemp_warn | (htf_q & ~(wr_ifr & wd[hbc_pkg::IFR_HTF]));
      hs_oc_q <= flt_s_q.hs_overcurrent | (hs_oc_q & ~(wr_stat & wd[hbc_pkg::STAT_HBOCF]));
      ls_oc_q <= flt_s_q.ls_overcurrent | (ls_oc_q & ~(wr_stat & wd[hbc_pkg::STAT_HBOCF]));
      // Thermal trip holds until the block is reset
      trip_q <= trip_q | (htre_q & flt_s_q.overtemp_limit);
    end
  end

  // Current limiting; codes 000 to 010 disable it
  logic       limit_on;
  logic [3:0] reenable;
  assign limit_on = (cls_q >= hbc_pkg::CLS_FIRST_LIMIT);
  assign reenable = ofc_q ? {chop_fall, chop_fall, chop_rise, chop_rise}
                          : {4{chop_rise}};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chop_off_q <= hbc_pkg::NIBBLE0;
    end else begin
      // A fresh limit hit wins over a same-cycle re-enable edge
      chop_off_q <= ({4{limit_on}} & br_s_q.limit_hit & ls_drive_q) |
                    (chop_off_q & ~reenable & {4{limit_on}});
    end
  end

  // Gate drive with priority, interlock and break-before-make
  logic [3:0] lamp_switch_on;
  logic [3:0] ls_on;
  logic       kill;
  logic [3:0] hs_want;
  logic [3:0] ls_want;
  assign lamp_switch_on   = side_bits(half_bridge_output_q, 1'b1);
  assign ls_on   = side_bits(half_bridge_output_q, 1'b0);
  assign kill    = ~pse_q | lvf_q | hvf_q | trip_q;
  assign hs_want = lamp_switch_on & {4{~kill & ~hs_oc_q}};
  assign ls_want = ls_on & ~lamp_switch_on & ~chop_off_q & {4{~kill & ~ls_oc_q}};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hs_drive_q <= hbc_pkg::NIBBLE0;
      ls_drive_q <= hbc_pkg::NIBBLE0;
      lamp_q     <= 1'b0;
      recirc_q   <= 1'b0;
    end else begin
      // Holding turn-on until the other gate is off avoids shoot-through
      hs_drive_q <= hs_want & br_s_q.ls_gate_off & ~ls_drive_q;
      ls_drive_q <= ls_want & br_s_q.hs_gate_off & ~hs_drive_q;
      // The thermal trip drops every power output, the lamp switch included
      lamp_q     <= pse_q & lamp_on_q & ~trip_q;
      recirc_q   <= |br_s_q.recirc;
    end
  end

  // Outputs
  assign avs_readdata         = rdata_q;
  assign avs_waitrequest      = wait_q;
  assign hs_drive             = hs_drive_q;
  assign ls_drive             = ls_drive_q;
  assign lamp_drive           = lamp_q;
  assign hall_input_enable    = hall_en_q;
  assign sense_gain_select    = gain_q;
  assign current_limit_select = cls_q;
  assign recirculation_detect = recirc_q;
  assign thermal_reset        = trip_q;

  // Checks
  sequence limit_cut_s;
    limit_on && (chop_off_q[0] == 1'b1);
  endsequence
  sequence edge_clear_s;
    !br_s_q.limit_hit[0] && chop_rise;
  endsequence

  no_shoot_a: assert property (@(posedge mclk) disable iff (reset)
    (hs_drive_q & ls_drive_q) == 4'h0) else $error("both MOSFETs of a bridge on");
  pse_off_a: assert property (@(posedge mclk) disable iff (reset)
    !pse_q |=> (hs_drive_q == 4'h0) && (ls_drive_q == 4'h0) && !lamp_q)
    else $error("outputs on without stage enable");
  hs_priority_a: assert property (@(posedge mclk) disable iff (reset)
    ((ls_drive_q & $past(lamp_switch_on)) == 4'h0)) else $error("low side on with high bit set");
  bbm_wait_a: assert property (@(posedge mclk) disable iff (reset)
    ((ls_drive_q & ~$past(br_s_q.hs_gate_off)) == 4'h0) &&
    ((hs_drive_q & ~$past(br_s_q.ls_gate_off)) == 4'h0)) else $error("turn on before opposite gate off");
  chop_reenable_a: assert property (@(posedge mclk) disable iff (reset)
    limit_cut_s ##0 edge_clear_s |=> !chop_off_q[0]) else $error("low side not re-armed on chop edge");
  volt_kill_a: assert property (@(posedge mclk) disable iff (reset)
    (lvf_q || hvf_q) |=> (hs_drive_q == 4'h0) && (ls_drive_q == 4'h0))
    else $error("bridge on during voltage fault");
  trip_kill_a: assert property (@(posedge mclk) disable iff (reset)
    trip_q |=> (hs_drive_q == 4'h0) && (ls_drive_q == 4'h0) && !lamp_q)
    else $error("power output on after thermal trip");
  oc_flag_a: assert property (@(posedge mclk) disable iff (reset)
    flt_s_q.hs_overcurrent |=> hs_oc_q ##1 (hs_drive_q == 4'h0)) else $error("high overcurrent not handled");
  oc_clear_a: assert property (@(posedge mclk) disable iff (reset)
    wr_stat && wd[hbc_pkg::STAT_HBOCF] && !flt_s_q.hs_overcurrent && !flt_s_q.ls_overcurrent
    |=> !hs_oc_q && !ls_oc_q) else $error("overcurrent flag not cleared");
  oc_keep_a: assert property (@(posedge mclk) disable iff (reset)
    (hs_oc_q && !(wr_stat && wd[hbc_pkg::STAT_HBOCF])) |=> hs_oc_q) else $error("overcurrent flag lost");
  hall_track_a: assert property (@(posedge mclk) disable iff (reset)
    ##1 (hall_flags_q == ($past(hall_s_q) & $past(hall_en_q)))) else $error("hall flag mismatch");
  bus_ack_a: assert property (@(posedge mclk) disable iff (reset)
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q) else $error("waitrequest timing wrong");

endmodule
`default_nettype wire

// ### hw/hbc_pkg.sv
// Package for the half-bridge output control block: register map, fields, carriers
`default_nettype none
package hbc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_HALF_BRIDGE_OUTPUT   = 4'h1;
  localparam logic [3:0] IDX_HALF_BRIDGE_CONTROL   = 4'h2;
  localparam logic [3:0] IDX_SYSTEM_CONTROL_REGISTER  = 4'h3;
  localparam logic [3:0] IDX_PROTCTL = 4'h4;
  localparam logic [3:0] IDX_IFR     = 4'h5;
  localparam logic [3:0] IDX_HACTL   = 4'h8;
  localparam logic [3:0] IDX_HASTAT  = 4'h9;
  localparam logic [3:0] IDX_POWER_OUTPUT_REGISTER    = 4'hB;
  localparam logic [3:0] IDX_SYSTEM_STATUS_REGISTER = 4'hC;
  // Field positions
  localparam int HALF_BRIDGE_CONTROL_OFC    = 7;
  localparam int HALF_BRIDGE_CONTROL_GAIN   = 6;
  localparam int SYSTEM_CONTROL_REGISTER_PSE   = 7;
  localparam int PROTCTL_HTRE = 0;
  localparam int IFR_LVF      = 0;
  localparam int IFR_HVF      = 1;
  localparam int IFR_HTF      = 2;
  localparam int POWER_OUTPUT_REGISTER_LAMP    = 0;
  localparam int STAT_HBOCF   = 0;
  localparam int STAT_LVF     = 1;
  localparam int STAT_HVF     = 2;
  localparam int STAT_HTF     = 3;
  // Reset values
  localparam logic [7:0] HALF_BRIDGE_OUTPUT_RST = 8'h00;
  localparam logic [2:0] CLS_RST   = 3'h0;
  localparam logic [3:0] NIBBLE0   = 4'h0;
  localparam logic [2:0] HALL0     = 3'h0;
  localparam logic [31:0] WORD0    = 32'h0000_0000;
  // Limit codes below this mean no limit
  localparam logic [2:0] CLS_FIRST_LIMIT = 3'h3;
  // Supply, thermal and overcurrent inputs
  typedef struct packed {
    logic low_voltage;
    logic high_voltage;
    logic overtemp_warn;
    logic overtemp_limit;
    logic hs_overcurrent;
    logic ls_overcurrent;
  } hbc_fault_t;
  // Per-bridge analog indications, bit 0 is bridge 1
  typedef struct packed {
    logic [3:0] limit_hit;
    logic [3:0] hs_gate_off;
    logic [3:0] ls_gate_off;
    logic [3:0] recirc;
  } hbc_bridge_sense_t;
endpackage
`default_nettype wire

// ### dv/hbc_bridge_model.sv
// Behavioural model of the four power half-bridges that the control block drives
`timescale 1ns/1ns
`default_nettype none
module hbc_bridge_model (
  // Clock
  input  wire logic                  mclk,
  // Gate commands and scenario controls
  input  wire logic [3:0]            hs_drive,
  input  wire logic [3:0]            ls_drive,
  input  wire logic                  slow,
  input  wire logic [3:0]            limit_req,
  input  wire logic [3:0]            recirc_req,
  // Indications back to the block
  output var hbc_pkg::hbc_bridge_sense_t bridge_in
);
  logic [3:0][3:0] hs_q = '0;
  logic [3:0][3:0] ls_q = '0;

  always @(posedge mclk) begin
    hs_q <= {hs_q[2:0], hs_drive};
    ls_q <= {ls_q[2:0], ls_drive};
  end

  // A slow gate needs four cycles to discharge; off is never reported early
  assign bridge_in = '{limit_hit:   limit_req & ls_q[0],
                       hs_gate_off: ~(hs_q[0] | (slow ? (hs_q[1] | hs_q[2] | hs_q[3]) : 4'h0)),
                       ls_gate_off: ~(ls_q[0] | (slow ? (ls_q[1] | ls_q[2] | ls_q[3]) : 4'h0)),
                       recirc:      recirc_req};
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the half-bridge output control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
`define WAITV(s, v) begin for (wc = 0; wc < 40 && (s) !== (v); wc++) @(posedge mclk); \
  `CHK(s, v) if ((s) !== (v)) conclude(); end
module tb_top;
  logic                        mclk, reset, avs_read, avs_write, avs_waitrequest;
  logic                        chop_clock_input, lamp_drive, sense_gain_select;
  logic                        recirculation_detect, thermal_reset, slow;
  logic [5:0]                  avs_address;
  logic [31:0]                 avs_writedata, avs_readdata;
  logic [3:0]                  hs_drive, ls_drive, limit_req, recirc_req;
  logic [2:0]                  hall_sense_in, hall_input_enable, current_limit_select;
  hbc_pkg::hbc_fault_t         flt;
  hbc_pkg::hbc_bridge_sense_t  bridge_in;
  logic [7:0]                  rd;
  int                          err_total, total_checks, wc;

  hbc_top i_hbc_top (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chop_clock_input(chop_clock_input),
    .hall_sense_in(hall_sense_in), .fault_in(flt), .bridge_in(bridge_in), .hs_drive(hs_drive),
    .ls_drive(ls_drive), .lamp_drive(lamp_drive), .hall_input_enable(hall_input_enable),
    .sense_gain_select(sense_gain_select), .current_limit_select(current_limit_select),
    .recirculation_detect(recirculation_detect), .thermal_reset(thermal_reset));
  hbc_bridge_model i_hbc_bridge_model (.mclk(mclk), .hs_drive(hs_drive), .ls_drive(ls_drive),
    .slow(slow), .limit_req(limit_req), .recirc_req(recirc_req), .bridge_in(bridge_in));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One Avalon transfer; always entered just after a rising edge
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, wd};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      conclude();
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic chop_edge(input logic v);
    repeat (500) @(posedge mclk);
    chop_clock_input <= v;
  endtask

  task automatic hit();
    limit_req <= 4'hF;
    repeat (3) @(posedge mclk);
    limit_req <= 4'h0;
  endtask

  // Neither MOSFET of a bridge conducts while the other's gate is not yet off
  always @(negedge mclk)
    if (reset === 1'b0)
      `CHK((ls_drive & ~bridge_in.hs_gate_off) | (hs_drive & ~bridge_in.ls_gate_off), 4'h0)

  initial begin
    reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0; avs_writedata = '0;
    chop_clock_input = 1'b0; hall_sense_in = 3'b101; flt = '0; slow = 1'b0;
    limit_req = 4'h0; recirc_req = 4'h0; err_total = 0; total_checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK({hs_drive, ls_drive, lamp_drive, thermal_reset}, 10'h000)
    bus(0, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 0); `CHK(rd, 8'h00)
    bus(0, hbc_pkg::IDX_HALF_BRIDGE_CONTROL, 0); `CHK(rd, 8'h00)
    `CHK({sense_gain_select, current_limit_select}, 4'h0)
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 8'h55);
    repeat (6) @(posedge mclk);
    `CHK(ls_drive, 4'h0)
    bus(0, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 0); `CHK(rd, 8'h55)
    bus(1, hbc_pkg::IDX_SYSTEM_CONTROL_REGISTER, 8'h80);
    `WAITV(ls_drive, 4'hF)
    bus(0, hbc_pkg::IDX_SYSTEM_CONTROL_REGISTER, 0); `CHK(rd, 8'h80)
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 8'h57);
    `WAITV({hs_drive, ls_drive}, 8'h1E)
    slow <= 1'b1;
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 8'hAA);
    `WAITV({hs_drive, ls_drive}, 8'hF0)
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 8'h55);
    `WAITV({hs_drive, ls_drive}, 8'h0F)
    slow <= 1'b0;
    $display("test interlock done");
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_CONTROL, 8'hFF); bus(0, hbc_pkg::IDX_HALF_BRIDGE_CONTROL, 0); `CHK(rd, 8'hC7)
    `CHK(sense_gain_select, 1'b1)
    for (int c = 0; c < 3; c++) begin
      bus(1, hbc_pkg::IDX_HALF_BRIDGE_CONTROL, 8'(c));
      `CHK(current_limit_select, 3'(c))
      hit();
      repeat (30) @(posedge mclk);
      `CHK(ls_drive, 4'hF)
    end
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_CONTROL, 8'h03);
    hit();
    `WAITV(ls_drive, 4'h0)
    repeat (30) @(posedge mclk);
    `CHK(ls_drive, 4'h0)
    chop_edge(1);
    `WAITV(ls_drive, 4'hF)
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_CONTROL, 8'h87);
    `CHK(current_limit_select, 3'h7)
    chop_edge(0);
    hit();
    `WAITV(ls_drive, 4'h0)
    chop_edge(1);
    `WAITV(ls_drive, 4'h3)
    repeat (30) @(posedge mclk);
    `CHK(ls_drive, 4'h3)
    chop_edge(0);
    `WAITV(ls_drive, 4'hF)
    $display("test chopping done");
    recirc_req <= 4'h4;
    `WAITV(recirculation_detect, 1'b1)
    recirc_req <= 4'h0;
    `WAITV(recirculation_detect, 1'b0)
    bus(1, hbc_pkg::IDX_HACTL, 8'h00); bus(0, hbc_pkg::IDX_HASTAT, 0); `CHK(rd, 8'h00)
    bus(1, hbc_pkg::IDX_HACTL, 8'h07); `CHK(hall_input_enable, 3'h7)
    bus(0, hbc_pkg::IDX_HASTAT, 0); `CHK(rd, 8'h05)
    bus(1, hbc_pkg::IDX_POWER_OUTPUT_REGISTER, 8'h01);
    `WAITV(lamp_drive, 1'b1)
    bus(1, 4'h6, 8'hFF); bus(0, 4'h6, 0); `CHK(rd, 8'h00)
    $display("test misc done");
    bus(1, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 8'h06);
    `WAITV({hs_drive, ls_drive}, 8'h12)
    flt.hs_overcurrent <= 1'b1; repeat (4) @(posedge mclk); flt.hs_overcurrent <= 1'b0;
    `WAITV(hs_drive, 4'h0)
    `CHK(ls_drive, 4'h2)
    bus(0, hbc_pkg::IDX_SYSTEM_STATUS_REGISTER, 0); `CHK(rd[0], 1'b1)
    bus(1, hbc_pkg::IDX_SYSTEM_STATUS_REGISTER, 8'h00); bus(0, hbc_pkg::IDX_SYSTEM_STATUS_REGISTER, 0); `CHK(rd[0], 1'b1)
    bus(1, hbc_pkg::IDX_SYSTEM_STATUS_REGISTER, 8'h01); bus(0, hbc_pkg::IDX_SYSTEM_STATUS_REGISTER, 0); `CHK(rd[0], 1'b0)
    `WAITV(hs_drive, 4'h1)
    flt.ls_overcurrent <= 1'b1; repeat (4) @(posedge mclk); flt.ls_overcurrent <= 1'b0;
    `WAITV(ls_drive, 4'h0)
    `CHK(hs_drive, 4'h1)
    bus(1, hbc_pkg::IDX_SYSTEM_STATUS_REGISTER, 8'h01);
    `WAITV(ls_drive, 4'h2)
    for (int k = 0; k < 2; k++) begin
      flt.low_voltage <= (k == 0); flt.high_voltage <= (k == 1);
      `WAITV({hs_drive, ls_drive}, 8'h00)
      bus(1, hbc_pkg::IDX_IFR, 8'(1 << k)); bus(0, hbc_pkg::IDX_IFR, 0); `CHK(rd[1:0], 2'(1 << k))
      flt.low_voltage <= 1'b0; flt.high_voltage <= 1'b0;
      repeat (4) @(posedge mclk);
      bus(1, hbc_pkg::IDX_IFR, 8'(1 << k)); bus(0, hbc_pkg::IDX_IFR, 0); `CHK(rd[1:0], 2'h0)
      `WAITV({hs_drive, ls_drive}, 8'h12)
    end
    $display("test protection done");
    flt.overtemp_warn <= 1'b1; repeat (4) @(posedge mclk); flt.overtemp_warn <= 1'b0;
    bus(0, hbc_pkg::IDX_IFR, 0); `CHK(rd[2], 1'b1)
    bus(1, hbc_pkg::IDX_PROTCTL, 8'h01);
    flt.overtemp_limit <= 1'b1;
    `WAITV(thermal_reset, 1'b1)
    `WAITV({hs_drive, ls_drive, lamp_drive}, 9'h000)
    flt.overtemp_limit <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK(thermal_reset, 1'b0)
    bus(0, hbc_pkg::IDX_HALF_BRIDGE_OUTPUT, 0); `CHK(rd, 8'h00)
    $display("test overtemp done");
    conclude();
  end
endmodule
`default_nettype wire
